// ### src/pwm_pkg.sv
package pwm_pkg;

  localparam int UNITS     = 3;
  localparam int BYTE_W    = 8;
  localparam int COUNT_W   = 16;
  localparam int IDX_W     = 4;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int MIRROR_W  = 3;
  localparam int UNIT_SEL_W = 2;

  // Address layout: unit select in [7:6], register index in [5:2]
  localparam int UNIT_FIELD_HI = 7;
  localparam int UNIT_FIELD_LO = 6;
  localparam int IDX_FIELD_HI  = 5;
  localparam int IDX_FIELD_LO  = 2;

  localparam logic [IDX_W-1:0] IDX_PHASE_LOW    = 4'h0;
  localparam logic [IDX_W-1:0] IDX_PHASE_HIGH   = 4'h1;
  localparam logic [IDX_W-1:0] IDX_DUTY_LOW     = 4'h2;
  localparam logic [IDX_W-1:0] IDX_DUTY_HIGH    = 4'h3;
  localparam logic [IDX_W-1:0] IDX_PERIOD_LOW   = 4'h4;
  localparam logic [IDX_W-1:0] IDX_PERIOD_HIGH  = 4'h5;
  localparam logic [IDX_W-1:0] IDX_OFFSET_LOW   = 4'h6;
  localparam logic [IDX_W-1:0] IDX_OFFSET_HIGH  = 4'h7;
  localparam logic [IDX_W-1:0] IDX_TIMER_LOW    = 4'h8;
  localparam logic [IDX_W-1:0] IDX_TIMER_HIGH   = 4'h9;
  localparam logic [IDX_W-1:0] IDX_UNIT_CONTROL = 4'hA;
  localparam logic [IDX_W-1:0] IDX_RELOAD_CTRL  = 4'hB;

  localparam logic [ADDR_W-1:0] ENABLE_MIRROR_ADDR   = 8'hC0;
  localparam logic [ADDR_W-1:0] LOAD_ARM_MIRROR_ADDR = 8'hC4;

  localparam int ENABLE_BIT    = 7;
  localparam int ARMED_BIT     = 7;
  localparam int WAIT_TRIG_BIT = 6;

  localparam logic [COUNT_W-1:0]  COUNT_ZERO  = 16'h0000;
  localparam logic [COUNT_W-1:0]  COUNT_ONE   = 16'h0001;
  localparam logic [BYTE_W-1:0]   BYTE_ZERO   = 8'h00;
  localparam logic [MIRROR_W-1:0] MIRROR_ZERO = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ANSWER = 2'b10
  } apb_state_t;

endpackage : pwm_pkg

// ### src/unit_if.sv
`timescale 1ns/1ps
interface unit_if;
  import pwm_pkg::*;
  logic              wr_en;
  logic [IDX_W-1:0]  wr_index;
  logic [BYTE_W-1:0] wr_data;
  logic [IDX_W-1:0]  rd_index;
  logic [BYTE_W-1:0] rd_data;
  logic              run;
  logic              armed;
  logic              wait_trig;
  logic              reload_done;
  logic              period_end;

  modport unit (input wr_en, wr_index, wr_data, rd_index, run, armed, wait_trig,
                output rd_data, reload_done, period_end);
  modport ctrl (output wr_en, wr_index, wr_data, rd_index, run, armed, wait_trig,
                input rd_data, reload_done, period_end);
endinterface : unit_if

// ### src/pwm_unit.sv
`timescale 1ns/1ps
module pwm_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  unit_if.unit     bus
);
  import pwm_pkg::*;

  logic [COUNT_W-1:0] phase_value, duty_value, period_value, offset_value;
  logic [COUNT_W-1:0] next_phase, next_duty, next_period, next_offset;
  logic [COUNT_W-1:0] phase_act, duty_act, period_act, offset_act;
  logic [COUNT_W-1:0] next_phase_act, next_duty_act, next_period_act, next_offset_act;
  logic [COUNT_W-1:0] timer_value, next_timer;
  logic               period_hit;
  logic               reload;

  function automatic logic [COUNT_W-1:0] put_byte(input logic [COUNT_W-1:0] v,
                                                  input logic hi,
                                                  input logic [BYTE_W-1:0] b);
    put_byte = hi ? {b, v[BYTE_W-1:0]} : {v[COUNT_W-1:BYTE_W], b};
  endfunction : put_byte

  function automatic logic [BYTE_W-1:0] get_byte(input logic [COUNT_W-1:0] v,
                                                 input logic hi);
    get_byte = hi ? v[COUNT_W-1:BYTE_W] : v[BYTE_W-1:0];
  endfunction : get_byte

  always_comb begin
    next_phase  = phase_value;
    next_duty   = duty_value;
    next_period = period_value;
    next_offset = offset_value;
    period_hit  = bus.run && (timer_value == period_act);
    reload      = period_hit && bus.armed && !bus.wait_trig;
    next_timer  = timer_value;
    if (bus.run) begin
      next_timer = period_hit ? COUNT_ZERO : timer_value + COUNT_ONE;
    end
    if (bus.wr_en) begin
      case (bus.wr_index)
        IDX_PHASE_LOW, IDX_PHASE_HIGH: next_phase = put_byte(phase_value, bus.wr_index[0], bus.wr_data);
        IDX_DUTY_LOW, IDX_DUTY_HIGH: next_duty = put_byte(duty_value, bus.wr_index[0], bus.wr_data);
        IDX_PERIOD_LOW, IDX_PERIOD_HIGH: next_period = put_byte(period_value, bus.wr_index[0], bus.wr_data);
        IDX_OFFSET_LOW, IDX_OFFSET_HIGH: next_offset = put_byte(offset_value, bus.wr_index[0], bus.wr_data);
        // Software write beats the count so a written value is seen exactly
        IDX_TIMER_LOW, IDX_TIMER_HIGH: next_timer = put_byte(timer_value, bus.wr_index[0], bus.wr_data);
        default: next_timer = next_timer;
      endcase
    end
    next_phase_act  = reload ? phase_value  : phase_act;
    next_duty_act   = reload ? duty_value   : duty_act;
    next_period_act = reload ? period_value : period_act;
    next_offset_act = reload ? offset_value : offset_act;
  end

  always_comb begin
    case (bus.rd_index)
      IDX_PHASE_LOW, IDX_PHASE_HIGH:   bus.rd_data = get_byte(phase_value, bus.rd_index[0]);
      IDX_DUTY_LOW, IDX_DUTY_HIGH:     bus.rd_data = get_byte(duty_value, bus.rd_index[0]);
      IDX_PERIOD_LOW, IDX_PERIOD_HIGH: bus.rd_data = get_byte(period_value, bus.rd_index[0]);
      IDX_OFFSET_LOW, IDX_OFFSET_HIGH: bus.rd_data = get_byte(offset_value, bus.rd_index[0]);
      IDX_TIMER_LOW, IDX_TIMER_HIGH:   bus.rd_data = get_byte(timer_value, bus.rd_index[0]);
      default:                         bus.rd_data = BYTE_ZERO;
    endcase
  end

  assign bus.reload_done = reload && pclken;
  assign bus.period_end  = period_hit && pclken;

  // Buffers have no reset: unknown at power-up, kept across later resets
  always_ff @(posedge pclk) begin
    if (pclken) begin
      phase_value  <= next_phase;
      duty_value   <= next_duty;
      period_value <= next_period;
      offset_value <= next_offset;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_value <= COUNT_ZERO;
      phase_act   <= COUNT_ZERO;
      duty_act    <= COUNT_ZERO;
      period_act  <= COUNT_ZERO;
      offset_act  <= COUNT_ZERO;
    end else if (pclken) begin
      timer_value <= next_timer;
      phase_act   <= next_phase_act;
      duty_act    <= next_duty_act;
      period_act  <= next_period_act;
      offset_act  <= next_offset_act;
    end
  end

endmodule : pwm_unit

// ### src/pwm_count_regs.sv
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Per-unit 16-bit phase, high and low bytes
// - Per-unit 16-bit duty, high and low bytes
// - Per-unit 16-bit period, high and low bytes
// - Per-unit 16-bit offset, high and low bytes
// - Running timer readable and writable per byte
// - Count buffers unknown at power-up, kept otherwise
// - Timer bytes cleared by every reset
// - Enable mirror bits 2..0 alias unit enables
// - Load mirror bits 2..0 alias load-armed bits
// - Mirror upper bits read zero; reset zero
// - Enable bit runs the unit, clear stops
// - Armed without trigger wait reloads at period end
// - Hardware clears arm after reload; software may cancel
module pwm_count_regs (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           pclken,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [pwm_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [pwm_pkg::DATA_W-1:0]     pwdata,
  output logic      [pwm_pkg::DATA_W-1:0]     prdata,
  output logic                                pready,
  output logic                                pslverr,
  output logic      [pwm_pkg::UNITS-1:0]      unit_enable,
  output logic      [pwm_pkg::UNITS-1:0]      unit_period_end,
  output logic      [pwm_pkg::UNITS-1:0]      unit_reload_done
);
  import pwm_pkg::*;

  apb_state_t          state, next_state;
  logic [DATA_W-1:0]   next_prdata;
  logic                next_pslverr;
  logic [UNITS-1:0]    enable, next_enable;
  logic [UNITS-1:0]    armed, next_armed;
  logic [UNITS-1:0]    wait_trig, next_wait_trig;
  logic [UNITS-1:0]    reload_done;
  logic [UNITS-1:0]    period_end;
  logic [UNITS-1:0]    count_wr;
  logic [UNITS-1:0]    next_period_end, next_reload_done;
  logic [BYTE_W-1:0]   unit_rd [UNITS];
  logic                wr_fire;
  logic [BYTE_W-1:0]   sel_byte;

  // Decoding shared by read capture, write strobes and unmapped detection
  function automatic logic [UNIT_SEL_W-1:0] addr_unit(input logic [ADDR_W-1:0] a);
    addr_unit = a[UNIT_FIELD_HI:UNIT_FIELD_LO];
  endfunction : addr_unit

  function automatic logic [IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] a);
    addr_idx = a[IDX_FIELD_HI:IDX_FIELD_LO];
  endfunction : addr_idx

  function automatic logic addr_in_unit(input logic [ADDR_W-1:0] a);
    addr_in_unit = (addr_unit(a) < UNIT_SEL_W'(UNITS)) && (addr_idx(a) <= IDX_RELOAD_CTRL)
                   && (a[IDX_FIELD_LO-1:0] == 2'h0);
  endfunction : addr_in_unit

  function automatic logic addr_valid(input logic [ADDR_W-1:0] a);
    addr_valid = addr_in_unit(a) || (a == ENABLE_MIRROR_ADDR) || (a == LOAD_ARM_MIRROR_ADDR);
  endfunction : addr_valid

  unit_if u_if [UNITS] ();

  genvar gi;
  generate
    for (gi = 0; gi < UNITS; gi++) begin : g_unit
      pwm_unit u_unit (
        .pclk    (pclk),
        .presetn (presetn),
        .pclken  (pclken),
        .bus     (u_if[gi])
      );
      assign count_wr[gi]       = wr_fire && addr_in_unit(paddr)
                                  && (addr_unit(paddr) == UNIT_SEL_W'(gi))
                                  && (addr_idx(paddr) <= IDX_TIMER_HIGH);
      assign u_if[gi].wr_en     = count_wr[gi];
      assign u_if[gi].wr_index  = addr_idx(paddr);
      assign u_if[gi].wr_data   = pwdata[BYTE_W-1:0];
      assign u_if[gi].rd_index  = addr_idx(paddr);
      assign u_if[gi].run       = enable[gi];
      assign u_if[gi].armed     = armed[gi];
      assign u_if[gi].wait_trig = wait_trig[gi];
      assign unit_rd[gi]        = u_if[gi].rd_data;
      assign reload_done[gi]    = u_if[gi].reload_done;
      assign period_end[gi]     = u_if[gi].period_end;
    end
  endgenerate

  // Bus side: read data is captured in the setup cycle so the access phase
  // answers at once from flip-flops, with no wait states except while pclken is low.
  assign pready  = pclken && (state == ST_ANSWER);
  assign wr_fire = psel && penable && pwrite && pready;

  always_comb begin
    sel_byte = BYTE_ZERO;
    case (addr_unit(paddr))
      2'h0:    sel_byte = unit_rd[0];
      2'h1:    sel_byte = unit_rd[1];
      2'h2:    sel_byte = unit_rd[2];
      default: sel_byte = BYTE_ZERO;
    endcase
  end

  always_comb begin
    next_state   = state;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    case (state)
      ST_IDLE: begin
        if (psel && !penable) begin
          next_state   = ST_ANSWER;
          next_pslverr = !addr_valid(paddr);
          next_prdata  = {DATA_W{1'b0}};
          if (!pwrite && addr_in_unit(paddr)) begin
            case (addr_idx(paddr))
              IDX_UNIT_CONTROL: next_prdata[ENABLE_BIT] = enable[addr_unit(paddr)];
              IDX_RELOAD_CTRL: begin
                next_prdata[ARMED_BIT]     = armed[addr_unit(paddr)];
                next_prdata[WAIT_TRIG_BIT] = wait_trig[addr_unit(paddr)];
              end
              default: next_prdata[BYTE_W-1:0] = sel_byte;
            endcase
          end else if (!pwrite && paddr == ENABLE_MIRROR_ADDR) begin
            next_prdata[MIRROR_W-1:0] = enable;
          end else if (!pwrite && paddr == LOAD_ARM_MIRROR_ADDR) begin
            next_prdata[MIRROR_W-1:0] = armed;
          end
        end
      end
      ST_ANSWER: begin
        if (psel && penable) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_IDLE;
      prdata  <= {DATA_W{1'b0}};
      pslverr <= 1'b0;
    end else if (pclken) begin
      state   <= next_state;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Control bits: hardware clear applied first, software write after it,
  // so a set arriving with the reload is kept.
  always_comb begin
    next_enable    = enable;
    next_armed     = armed & ~reload_done;
    next_wait_trig = wait_trig;
    if (wr_fire && addr_in_unit(paddr)) begin
      case (addr_idx(paddr))
        IDX_UNIT_CONTROL: next_enable[addr_unit(paddr)] = pwdata[ENABLE_BIT];
        IDX_RELOAD_CTRL: begin
          next_armed[addr_unit(paddr)]     = pwdata[ARMED_BIT];
          next_wait_trig[addr_unit(paddr)] = pwdata[WAIT_TRIG_BIT];
        end
        default: next_enable = next_enable;
      endcase
    end
    // Mirrors are evaluated last and so win any collision
    if (wr_fire && paddr == ENABLE_MIRROR_ADDR) begin
      next_enable = pwdata[MIRROR_W-1:0];
    end
    if (wr_fire && paddr == LOAD_ARM_MIRROR_ADDR) begin
      next_armed = pwdata[MIRROR_W-1:0];
    end
    next_period_end  = period_end;
    next_reload_done = reload_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable           <= MIRROR_ZERO;
      armed            <= MIRROR_ZERO;
      wait_trig        <= MIRROR_ZERO;
      unit_period_end  <= MIRROR_ZERO;
      unit_reload_done <= MIRROR_ZERO;
    end else if (pclken) begin
      enable           <= next_enable;
      armed            <= next_armed;
      wait_trig        <= next_wait_trig;
      unit_period_end  <= next_period_end;
      unit_reload_done <= next_reload_done;
    end
  end

  assign unit_enable = enable;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_enable_mirror_wr: assert property (
    pclken && wr_fire && paddr == ENABLE_MIRROR_ADDR
    |=> enable == $past(pwdata[MIRROR_W-1:0]))
    else $error("enable mirror write not applied to all units");

  a_load_mirror_wr: assert property (
    pclken && wr_fire && paddr == LOAD_ARM_MIRROR_ADDR
    |=> armed == $past(pwdata[MIRROR_W-1:0]))
    else $error("load mirror write not applied to all units");

  a_mirror_read_zero: assert property (
    pready && !pwrite && (paddr == ENABLE_MIRROR_ADDR || paddr == LOAD_ARM_MIRROR_ADDR)
    |-> prdata[DATA_W-1:MIRROR_W] == '0)
    else $error("mirror upper bits not zero");

  a_mirror_read_val: assert property (
    pclken && psel && !penable && !pwrite && paddr == ENABLE_MIRROR_ADDR
    ##1 !(pclken && wr_fire) |-> prdata[MIRROR_W-1:0] == enable)
    else $error("enable mirror read mismatch");

  a_own_enable_wr: assert property (
    pclken && wr_fire && paddr == {2'h0, IDX_UNIT_CONTROL, 2'h0}
    |=> enable[0] == $past(pwdata[ENABLE_BIT]))
    else $error("unit control enable write lost");

  a_reload_cause: assert property (
    reload_done[0] |-> armed[0] && !wait_trig[0] && enable[0])
    else $error("reload without arm");

  a_reload_clears: assert property (
    reload_done[0] && !wr_fire |=> !armed[0])
    else $error("armed bit not cleared after reload");

  a_reset_values: assert property (
    !$past(presetn) |-> enable == MIRROR_ZERO && armed == MIRROR_ZERO)
    else $error("control bits not zero after reset");

  a_count_strobe: assert property (
    pclken && wr_fire && paddr == {2'h1, IDX_TIMER_HIGH, 2'h0} |-> count_wr == 3'h2)
    else $error("count write steered to wrong unit");

  a_answer_timing: assert property (
    pclken && psel && !penable && state == ST_IDLE ##1 pclken |-> pready)
    else $error("no answer in access phase");

  c_mirror_start: cover property (wr_fire && paddr == ENABLE_MIRROR_ADDR && pwdata[2:0] == 3'h7);
  c_reload: cover property (reload_done[0]);
  c_back_to_back: cover property (wr_fire ##1 psel && !penable ##1 pready);
  c_unmapped: cover property (pready && pslverr);

endmodule : pwm_count_regs

// ### sim/pwm_count_regs_test.sv
`timescale 1ns/1ps
module pwm_count_regs_test;
  import pwm_pkg::*;
  logic                pclk;
  logic                presetn;
  logic                pclken;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata;
  logic [DATA_W-1:0]   prdata;
  logic                pready;
  logic                pslverr;
  logic [UNITS-1:0]    unit_enable;
  logic [UNITS-1:0]    unit_period_end;
  logic [UNITS-1:0]    unit_reload_done;
  logic [DATA_W-1:0]   rdat;
  logic                rerr;
  int                  bad_count = 0;
  int                  checked = 0;
  int                  reload_cnt [UNITS] = '{default: 0};
  int                  end_cnt [UNITS] = '{default: 0};

  pwm_count_regs pwm_count_regs_inst (
    .pclk             (pclk),
    .presetn          (presetn),
    .pclken           (pclken),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .unit_enable      (unit_enable),
    .unit_period_end  (unit_period_end),
    .unit_reload_done (unit_reload_done)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Pulses are one cycle wide, so count them mid-cycle rather than poll from the tests
  always @(negedge pclk) begin
    for (int u = 0; u < UNITS; u++) begin
      reload_cnt[u] += int'(unit_reload_done[u] === 1'b1);
      end_cnt[u] += int'(unit_period_end[u] === 1'b1);
    end
  end

  function automatic logic [ADDR_W-1:0] reg_addr(input int u, input logic [IDX_W-1:0] i);
    reg_addr = {u[1:0], i, 2'b00};
  endfunction : reg_addr

  task automatic stop_test;
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic compare_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : compare_word

  task automatic compare_bits(input logic [UNITS-1:0] got, input logic [UNITS-1:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t bits got %b expected %b", $time, got, exp);
    end
  endtask : compare_bits

  // Setup, access until pready, then one idle cycle so the next call starts cleanly
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("[ERR] %0t no pready", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    compare_word(rdat, exp);
    compare_bits({2'b00, rerr}, 3'h0);
  endtask : rd_chk

  task automatic test_reset_values;
    for (int u = 0; u < UNITS; u++) begin
      rd_chk(reg_addr(u, IDX_TIMER_LOW), 32'h0000_0000);
      rd_chk(reg_addr(u, IDX_TIMER_HIGH), 32'h0000_0000);
    end
    rd_chk(ENABLE_MIRROR_ADDR, 32'h0000_0000);
    rd_chk(LOAD_ARM_MIRROR_ADDR, 32'h0000_0000);
    compare_bits(unit_enable, 3'h0);
  endtask : test_reset_values

  // Write every byte first, then read all back, so aliasing between places shows up
  task automatic test_count_regs;
    for (int u = 0; u < UNITS; u++) begin
      for (int i = 0; i < 10; i++) begin
        wr(reg_addr(u, i[3:0]), 32'hFFFF_FF00 | DATA_W'(8'h11 * (i + 1) + u));
      end
    end
    for (int u = 0; u < UNITS; u++) begin
      for (int i = 0; i < 10; i++) begin
        rd_chk(reg_addr(u, i[3:0]), DATA_W'(8'(8'h11 * (i + 1) + u)));
      end
    end
  endtask : test_count_regs

  task automatic test_mirrors;
    wr(ENABLE_MIRROR_ADDR, 32'h0000_00FF);
    compare_bits(unit_enable, 3'h7);
    rd_chk(ENABLE_MIRROR_ADDR, 32'h0000_0007);
    wr(ENABLE_MIRROR_ADDR, 32'h0000_0005);
    compare_bits(unit_enable, 3'h5);
    rd_chk(reg_addr(0, IDX_UNIT_CONTROL), 32'h0000_0080);
    rd_chk(reg_addr(1, IDX_UNIT_CONTROL), 32'h0000_0000);
    wr(reg_addr(1, IDX_UNIT_CONTROL), 32'h0000_0080);
    rd_chk(ENABLE_MIRROR_ADDR, 32'h0000_0007);
    wr(reg_addr(0, IDX_UNIT_CONTROL), 32'h0000_0000);
    rd_chk(ENABLE_MIRROR_ADDR, 32'h0000_0006);
    // Arming while running would reload at the next period end, so stop every unit first
    wr(ENABLE_MIRROR_ADDR, 32'h0000_0000);
    wr(LOAD_ARM_MIRROR_ADDR, 32'h0000_00FF);
    rd_chk(LOAD_ARM_MIRROR_ADDR, 32'h0000_0007);
    for (int u = 0; u < UNITS; u++) begin
      rd_chk(reg_addr(u, IDX_RELOAD_CTRL), 32'h0000_0080);
    end
    wr(reg_addr(2, IDX_RELOAD_CTRL), 32'h0000_0000);
    rd_chk(LOAD_ARM_MIRROR_ADDR, 32'h0000_0003);
    wr(LOAD_ARM_MIRROR_ADDR, 32'h0000_0000);
    rd_chk(reg_addr(0, IDX_RELOAD_CTRL), 32'h0000_0000);
  endtask : test_mirrors

  task automatic test_reload;
    int r0;
    int e0;
    wr(reg_addr(0, IDX_PERIOD_LOW), 32'h0000_0005);
    wr(reg_addr(0, IDX_PERIOD_HIGH), 32'h0000_0000);
    wr(reg_addr(0, IDX_TIMER_LOW), 32'h0000_0000);
    wr(reg_addr(0, IDX_TIMER_HIGH), 32'h0000_0000);
    r0 = reload_cnt[0];
    wr(reg_addr(0, IDX_RELOAD_CTRL), 32'h0000_0080);
    wr(ENABLE_MIRROR_ADDR, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    compare_word(DATA_W'(reload_cnt[0] - r0), 32'h0000_0001);
    rd_chk(LOAD_ARM_MIRROR_ADDR, 32'h0000_0000);
    e0 = end_cnt[0];
    repeat (20) @(posedge pclk);
    compare_bits({2'b00, end_cnt[0] > e0}, 3'h1);
    wr(ENABLE_MIRROR_ADDR, 32'h0000_0000);
    wr(reg_addr(0, IDX_TIMER_LOW), 32'h0000_0042);
    e0 = end_cnt[0];
    repeat (20) @(posedge pclk);
    compare_word(DATA_W'(end_cnt[0] - e0), 32'h0000_0000);
    rd_chk(reg_addr(0, IDX_TIMER_LOW), 32'h0000_0042);
  endtask : test_reload

  // Unit 0 stays frozen with the clock enable low although it is enabled
  task automatic test_clock_enable;
    int e0;
    wr(reg_addr(0, IDX_TIMER_LOW), 32'h0000_0000);
    wr(ENABLE_MIRROR_ADDR, 32'h0000_0001);
    pclken <= 1'b0;
    e0 = end_cnt[0];
    repeat (20) @(posedge pclk);
    compare_word(DATA_W'(end_cnt[0] - e0), 32'h0000_0000);
    pclken <= 1'b1;
    repeat (20) @(posedge pclk);
    compare_bits({2'b00, end_cnt[0] > e0}, 3'h1);
    wr(ENABLE_MIRROR_ADDR, 32'h0000_0000);
  endtask : test_clock_enable

  // Timer at zero matches the reset period at once, so only the wait bit holds the load
  task automatic test_wait_trigger;
    int r1;
    int e1;
    wr(reg_addr(1, IDX_TIMER_LOW), 32'h0000_0000);
    wr(reg_addr(1, IDX_TIMER_HIGH), 32'h0000_0000);
    r1 = reload_cnt[1];
    e1 = end_cnt[1];
    wr(reg_addr(1, IDX_RELOAD_CTRL), 32'h0000_00C0);
    wr(ENABLE_MIRROR_ADDR, 32'h0000_0002);
    repeat (30) @(posedge pclk);
    compare_bits({2'b00, end_cnt[1] > e1}, 3'h1);
    compare_word(DATA_W'(reload_cnt[1] - r1), 32'h0000_0000);
    rd_chk(reg_addr(1, IDX_RELOAD_CTRL), 32'h0000_00C0);
    rd_chk(LOAD_ARM_MIRROR_ADDR, 32'h0000_0002);
    wr(reg_addr(1, IDX_RELOAD_CTRL), 32'h0000_0040);
    rd_chk(LOAD_ARM_MIRROR_ADDR, 32'h0000_0000);
    wr(ENABLE_MIRROR_ADDR, 32'h0000_0000);
  endtask : test_wait_trigger

  task automatic test_unmapped;
    apb(1'b0, 8'hC8, 32'h0000_0000);
    compare_bits({2'b00, rerr}, 3'h1);
    compare_word(rdat, 32'h0000_0000);
    apb(1'b1, reg_addr(0, 4'hC), 32'h0000_00FF);
    compare_bits({2'b00, rerr}, 3'h1);
  endtask : test_unmapped

  task automatic test_mid_reset;
    wr(reg_addr(1, IDX_PHASE_HIGH), 32'h0000_00A5);
    wr(reg_addr(2, IDX_TIMER_LOW), 32'h0000_0033);
    wr(ENABLE_MIRROR_ADDR, 32'h0000_0002);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(reg_addr(1, IDX_PHASE_HIGH), 32'h0000_00A5);
    rd_chk(reg_addr(2, IDX_TIMER_LOW), 32'h0000_0000);
    rd_chk(ENABLE_MIRROR_ADDR, 32'h0000_0000);
    compare_bits(unit_enable, 3'h0);
  endtask : test_mid_reset

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    presetn = 1'b0;
    pclken = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset_values();
    test_count_regs();
    test_mirrors();
    test_reload();
    test_clock_enable();
    test_wait_trigger();
    test_unmapped();
    test_mid_reset();
    stop_test();
  end
endmodule : pwm_count_regs_test
